// File: core/cmpc_sample_div.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_sample_div #(
    parameter int CNT_W = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic       src_tick,
    input  wire logic [2:0] div_sel,
    output logic            sample_strobe
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } cmpc_div_s;

    cmpc_div_s        s_q;
    cmpc_div_s        s_d;
    logic [CNT_W-1:0] last_cnt;

    always_comb begin
        // Code 111 falls back to divide by one
        if (div_sel > cmpc_pkg::DIV_MAX_CODE) begin
            last_cnt = '0;
        end else begin
            last_cnt = CNT_W'((1 << div_sel) - 1);
        end
        s_d = s_q;
        sample_strobe = 1'b0;
        if (!run) begin
            s_d.cnt = '0;
        end else if (src_tick) begin
            if (s_q.cnt >= last_cnt) begin
                s_d.cnt = '0;
                sample_strobe = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// File: core/cmpc_top.sv
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module cmpc_top #(
    parameter int ADDR_W          = 18,
    parameter int EXIT_LS_WIN_CYC = cmpc_pkg::EXIT_LS_WIN_CYC,
    parameter int EXIT_HS_WIN_CYC = cmpc_pkg::EXIT_HS_WIN_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              compare_raw,
    input  wire logic              high_speed_clock_tick,
    input  wire logic              low_speed_clock_tick,
    input  wire logic              high_osc_enable,
    input  wire logic              low_power_mode,
    input  wire logic              cpu_on_high_clock,
    output logic                   compare_enable,
    output logic                   ref_source_select,
    output logic                   compare_result,
    output logic                   compare_irq
);

    localparam int WW = cmpc_pkg::WIN_W;

    typedef struct packed {
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              enable;
        logic              result;
        logic [1:0]        edge_sel;
        logic [1:0]        src_sel;
        logic [2:0]        div_sel;
        logic              vref_sel;
        logic              sync1;
        logic              sync2;
        logic              irq;
        cmpc_pkg::cmpc_pwr_e pwr;
        logic [WW-1:0]     win;
    } cmpc_state_s;

    cmpc_state_s   s_q;
    cmpc_state_s   s_d;
    logic          samp_active;
    logic          src_tick;
    logic          strobe;
    logic          new_result;
    logic          rise;
    logic          fall;
    logic          edge_hit;
    logic          irq_blocked;
    logic [15:0]   w_idx;
    logic [15:0]   r_idx;
    logic [WW-1:0] exit_cnt;

    // Sampling clock is gone in low power, and the high source needs its oscillator
    always_comb begin
        samp_active = 1'b0;
        src_tick = 1'b0;
        if (!low_power_mode) begin
            if (s_q.src_sel == cmpc_pkg::SRC_HIGH && high_osc_enable) begin
                samp_active = 1'b1;
                src_tick = high_speed_clock_tick;
            end else if (s_q.src_sel == cmpc_pkg::SRC_LOW) begin
                samp_active = 1'b1;
                src_tick = low_speed_clock_tick;
            end
        end
    end

    cmpc_sample_div #(
        .CNT_W (6)
    ) u_div (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .run           (s_q.enable && samp_active),
        .src_tick      (src_tick),
        .div_sel       (s_q.div_sel),
        .sample_strobe (strobe)
    );

    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign w_idx = s_q.aw_addr[17:2];
    assign r_idx = s_axi_araddr[17:2];
    assign exit_cnt = cpu_on_high_clock ? WW'(EXIT_HS_WIN_CYC) : WW'(EXIT_LS_WIN_CYC);
    assign irq_blocked = (s_q.pwr == cmpc_pkg::CMPC_PWR_ENTER)
                      || (s_q.pwr == cmpc_pkg::CMPC_PWR_EXIT);

    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.sync1 = compare_raw;
        s_d.sync2 = s_q.sync1;

        // Result takes the sampled value on a strobe, the raw one with no sample source, and holds when disabled
        new_result = s_q.result;
        if (s_q.enable) begin
            // High source without its oscillator falls back to detection without sampling
            if ((s_q.src_sel == cmpc_pkg::SRC_HIGH && high_osc_enable)
                    || s_q.src_sel == cmpc_pkg::SRC_LOW) begin
                if (strobe) begin
                    new_result = s_q.sync2;
                end
            end else begin
                new_result = s_q.sync2;
            end
        end
        s_d.result = new_result;
        rise = new_result && !s_q.result;
        fall = !new_result && s_q.result;
        case (s_q.edge_sel)
            cmpc_pkg::EDGE_FALL: edge_hit = fall;
            cmpc_pkg::EDGE_RISE: edge_hit = rise;
            cmpc_pkg::EDGE_BOTH: edge_hit = rise || fall;
            default:             edge_hit = 1'b0;
        endcase
        s_d.irq = edge_hit && !irq_blocked;

        // Interrupt blocking windows around low-power transitions
        case (s_q.pwr)
            cmpc_pkg::CMPC_PWR_RUN: begin
                if (low_power_mode) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_ENTER;
                    s_d.win = WW'(cmpc_pkg::ENTER_WIN_CYC);
                end
            end
            cmpc_pkg::CMPC_PWR_ENTER: begin
                if (!low_power_mode) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_EXIT;
                    s_d.win = exit_cnt;
                end else if (s_q.win <= WW'(1)) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_LOW;
                end else begin
                    s_d.win = s_q.win - WW'(1);
                end
            end
            cmpc_pkg::CMPC_PWR_LOW: begin
                if (!low_power_mode) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_EXIT;
                    s_d.win = exit_cnt;
                end
            end
            default: begin
                if (low_power_mode) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_ENTER;
                    s_d.win = WW'(cmpc_pkg::ENTER_WIN_CYC);
                end else if (s_q.win <= WW'(1)) begin
                    s_d.pwr = cmpc_pkg::CMPC_PWR_RUN;
                end else begin
                    s_d.win = s_q.win - WW'(1);
                end
            end
        endcase

        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = cmpc_pkg::RESP_OKAY;
            if (w_idx == cmpc_pkg::CTRL_IDX) begin
                if (s_q.wstrb[0]) begin
                    s_d.enable = s_q.wdata[cmpc_pkg::CTRL_EN_BIT];
                end
            end else if (w_idx == cmpc_pkg::MODE_LO_IDX) begin
                // Mode writes while enabled are accepted; their effect is unguaranteed
                if (s_q.wstrb[0]) begin
                    s_d.edge_sel = s_q.wdata[cmpc_pkg::MODE_EDGE_LSB +: 2];
                    s_d.src_sel = s_q.wdata[cmpc_pkg::MODE_SRC_LSB +: 2];
                    s_d.div_sel = s_q.wdata[cmpc_pkg::MODE_DIV_LSB +: 3];
                end
                if (s_q.wstrb[1]) begin
                    s_d.vref_sel = s_q.wdata[cmpc_pkg::MODE_VREF_BIT];
                end
            end else if (w_idx == cmpc_pkg::MODE_HI_IDX) begin
                if (s_q.wstrb[0]) begin
                    s_d.vref_sel = s_q.wdata[0];
                end
            end else if (w_idx != cmpc_pkg::RSVD_IDX) begin
                s_d.bresp = cmpc_pkg::RESP_SLVERR;
            end
        end

        // Read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = '0;
            s_d.rresp = cmpc_pkg::RESP_OKAY;
            if (r_idx == cmpc_pkg::CTRL_IDX) begin
                s_d.rdata[cmpc_pkg::CTRL_EN_BIT] = s_q.enable;
                s_d.rdata[cmpc_pkg::CTRL_RES_BIT] = s_q.result;
            end else if (r_idx == cmpc_pkg::MODE_LO_IDX) begin
                s_d.rdata[cmpc_pkg::MODE_EDGE_LSB +: 2] = s_q.edge_sel;
                s_d.rdata[cmpc_pkg::MODE_SRC_LSB +: 2] = s_q.src_sel;
                s_d.rdata[cmpc_pkg::MODE_DIV_LSB +: 3] = s_q.div_sel;
                s_d.rdata[cmpc_pkg::MODE_VREF_BIT] = s_q.vref_sel;
            end else if (r_idx == cmpc_pkg::MODE_HI_IDX) begin
                s_d.rdata[0] = s_q.vref_sel;
            end else if (r_idx != cmpc_pkg::RSVD_IDX) begin
                s_d.rresp = cmpc_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
            s_q.pwr <= cmpc_pkg::CMPC_PWR_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_bvalid      = s_q.bvalid;
    assign s_axi_bresp       = s_q.bresp;
    assign s_axi_rvalid      = s_q.rvalid;
    assign s_axi_rdata       = s_q.rdata;
    assign s_axi_rresp       = s_q.rresp;
    assign compare_enable    = s_q.enable;
    assign ref_source_select = s_q.vref_sel;
    assign compare_result    = s_q.result;
    assign compare_irq       = s_q.irq;

endmodule

`default_nettype wire

// File: shared/cmpc_pkg.sv
// Overview of operation
// - Reference select one compares the plus input against the internal fixed reference.
// - In stop, deep stop and high-speed halt no sampling happens.
// - Interrupts are blocked for a bounded window around low-power entry and return.
// - High-speed sampling with the high oscillator disabled gives no sampling.
// - Result reads one when plus input exceeds the selected reference, else zero.
// - Enable bit one starts comparator operation, zero stops it.
// - Clearing enable freezes the result bit at its current value.
// - The selected edge on the comparison result raises a comparator interrupt request.
// - Edge select: 00 none, 01 falling, 10 rising, 11 both.
// - Sample select: 00 none, 01 high-speed, 10 low-speed, 11 none.
// - Divider codes 000 to 110 divide by 1 to 64, 111 divides by one.
// - Control register: enable at bit 0, read-only result at bit 1, reset zero.
package cmpc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] CTRL_IDX      = 16'hF840;
    localparam logic [15:0] RSVD_IDX      = 16'hF841;
    localparam logic [15:0] MODE_LO_IDX   = 16'hF842;
    localparam logic [15:0] MODE_HI_IDX   = 16'hF843;

    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_RES_BIT    = 1;
    localparam int MODE_EDGE_LSB   = 0;
    localparam int MODE_SRC_LSB    = 2;
    localparam int MODE_DIV_LSB    = 4;
    localparam int MODE_VREF_BIT   = 8;

    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [1:0] SRC_NONE  = 2'h0;
    localparam logic [1:0] SRC_HIGH  = 2'h1;
    localparam logic [1:0] SRC_LOW   = 2'h2;

    localparam logic [2:0] DIV_MAX_CODE = 3'h6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [7:0]  CTRL_RESET = 8'h00;

    localparam int CLK_PERIOD_NS     = 50;
    localparam int ENTER_WIN_NS      = 30000;
    localparam int EXIT_LS_WIN_NS    = 250000;
    localparam int EXIT_HS_WIN_NS    = 2500000;
    // Longest times, so they round down
    localparam int ENTER_WIN_CYC     = ENTER_WIN_NS / CLK_PERIOD_NS;
    localparam int EXIT_LS_WIN_CYC   = EXIT_LS_WIN_NS / CLK_PERIOD_NS;
    localparam int EXIT_HS_WIN_CYC   = EXIT_HS_WIN_NS / CLK_PERIOD_NS;
    localparam int WIN_W             = 16;

    typedef enum logic [1:0] {
        CMPC_PWR_RUN   = 2'b00,
        CMPC_PWR_ENTER = 2'b01,
        CMPC_PWR_LOW   = 2'b11,
        CMPC_PWR_EXIT  = 2'b10
    } cmpc_pwr_e;

endpackage

// File: verification/cmpc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_analog_model (
    input  wire logic        clk_sys,
    input  wire logic        compare_enable,
    input  wire logic        ref_source_select,
    input  wire logic [11:0] plus_mv,
    input  wire logic [11:0] minus_mv,
    output logic             compare_raw
);
    // Internal reference in millivolts
    localparam logic [11:0] INT_REF_MV = 12'h320;
    logic live;
    // A stopped stage gives no trustworthy level: show the opposite of the last live one
    logic off_level_q = 1'b0;
    always_comb begin
        if (ref_source_select) live = plus_mv > INT_REF_MV;
        else live = plus_mv > minus_mv;
    end
    always @(posedge clk_sys) if (compare_enable) off_level_q <= !live;
    always_comb compare_raw = compare_enable ? live : off_level_q;
endmodule
`default_nettype wire

// File: verification/cmpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_monitor #(
    parameter int ADDR_W = 18
) (
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              compare_enable,
    input wire logic              ref_source_select,
    input wire logic              compare_result,
    input wire logic              compare_irq
);
    localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'({cmpc_pkg::CTRL_IDX, 2'h0});
    localparam logic [ADDR_W-1:0] MODE_A = ADDR_W'({cmpc_pkg::MODE_LO_IDX, 2'h0});
    // Write data ready equals address ready while address and data arrive together
    wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    a_irq_pulse: assert property (compare_irq |=> !compare_irq)
        else $error("irq wider than one cycle");
    a_irq_on_edge: assert property (compare_irq
        |-> compare_result != $past(compare_result)) else $error("irq without result change");
    a_off_frozen: assert property (!$past(compare_enable)
        |-> $stable(compare_result) && !compare_irq) else $error("result moved while off");
    a_reset_clear: assert property (disable iff (1'b0) srst
        |=> !compare_enable && !compare_result && !compare_irq) else $error("reset missed");
    a_enable_write: assert property (wr_go && s_axi_wstrb[0] && s_axi_awaddr == CTRL_A
        |=> ##1 compare_enable == $past(s_axi_wdata[0], 2)) else $error("enable not written");
    a_vref_write: assert property (wr_go && s_axi_wstrb[1] && s_axi_awaddr == MODE_A
        |=> ##1 ref_source_select == $past(s_axi_wdata[8], 2)) else $error("vref not written");
    a_write_answer: assert property (wr_go |=> ##1 s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    c_irq: cover property (compare_irq);
    c_frozen_high: cover property (!compare_enable && compare_result);
    c_write: cover property (wr_go);
endmodule

bind cmpc_top cmpc_monitor #(.ADDR_W(ADDR_W)) u_monitor (
    .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .compare_enable(compare_enable), .ref_source_select(ref_source_select),
    .compare_result(compare_result), .compare_irq(compare_irq)
);
`default_nettype wire

// File: verification/cmpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_tb_top;
    localparam logic [17:0] A_CTRL = {cmpc_pkg::CTRL_IDX, 2'h0};
    localparam logic [17:0] A_MODE = {cmpc_pkg::MODE_LO_IDX, 2'h0};
    localparam logic [1:0]  OK     = cmpc_pkg::RESP_OKAY;
    localparam logic [11:0] HI     = 12'h4B0;
    localparam logic [11:0] LO     = 12'h258;
    logic        clk_sys = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, hs_tick = 1'b0, ls_tick = 1'b0, osc_en = 1'b0;
    logic        low_pwr = 1'b0, cpu_hi = 1'b0, res_n = 1'b0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic [11:0] plus_mv = LO, minus_mv = 12'h3E8;
    logic        awready, wready, bvalid, arready, rvalid, enable, vref, result, irq, raw;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          failures = 0, check_count = 0, irq_count = 0, n, c;
    always #25 clk_sys = ~clk_sys;
    // Mirrors taken mid-cycle so tasks never race the design's edge
    always @(negedge clk_sys) begin
        res_n <= result;
        if (irq === 1'b1) irq_count <= irq_count + 1;
    end
    cmpc_top #(.EXIT_LS_WIN_CYC(20), .EXIT_HS_WIN_CYC(40)) dut (
        .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .compare_raw(raw), .high_speed_clock_tick(hs_tick), .low_speed_clock_tick(ls_tick),
        .high_osc_enable(osc_en), .low_power_mode(low_pwr), .cpu_on_high_clock(cpu_hi),
        .compare_enable(enable), .ref_source_select(vref), .compare_result(result),
        .compare_irq(irq));
    cmpc_analog_model partner (.clk_sys(clk_sys), .compare_enable(enable),
        .ref_source_select(vref), .plus_mv(plus_mv), .minus_mv(minus_mv), .compare_raw(raw));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("bresp", 32'(r), 32'(er));
        cyc(1);
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, got;
        logic [31:0] d;
        logic [1:0] r;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(negedge clk_sys);
            ta = arvalid && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk("rdata", d, ed);
        chk("rresp", 32'(r), 32'(er));
        cyc(1);
    endtask
    task automatic setup(input logic [15:0] mode);
        wr(A_CTRL, 32'h0, 4'h1, OK);
        wr(A_MODE, {16'h0, mode}, 4'h3, OK);
        wr(A_CTRL, 32'h1, 4'h1, OK);
        cyc(10);
    endtask
    task automatic flip(input logic [11:0] mv, input int e);
        int k;
        k = irq_count;
        plus_mv <= mv;
        cyc(8);
        chk("irq pulses", 32'(irq_count - k), 32'(e));
    endtask
    task automatic ticks(input logic hi, input logic want);
        n = 0;
        while (n < 70 && res_n !== want) begin
            {hs_tick, ls_tick} <= hi ? 2'h2 : 2'h1;
            cyc(1);
            {hs_tick, ls_tick} <= 2'h0;
            cyc(6);
            n++;
        end
    endtask
    task automatic tally_and_finish();
        $display("%0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        srst <= 1'b0;
        cyc(1);
        chk("outputs", 32'({enable, vref, result, irq}), 32'h0);
        rd(A_CTRL, 32'h0, OK);
        rd(A_MODE, 32'h0, OK);
        rd(A_CTRL + 18'h4, 32'h0, OK);
        rd(18'h00040, 32'h0, cmpc_pkg::RESP_SLVERR);
        wr(18'h00040, 32'h1, 4'hF, cmpc_pkg::RESP_SLVERR);
        $display("reset test done");
        setup(16'h0102);
        plus_mv <= 12'h384;
        cyc(8);
        chk("vref", 32'(vref), 32'h1);
        rd(A_CTRL, 32'h3, OK);
        rd(A_MODE, 32'h00000102, OK);
        rd(A_MODE + 18'h4, 32'h1, OK);
        wr(A_CTRL, 32'h0, 4'h1, OK);
        flip(LO, 0);
        cyc(20);
        rd(A_CTRL, 32'h2, OK);
        chk("enable", 32'(enable), 32'h0);
        $display("freeze test done");
        for (c = 0; c < 4; c++) begin
            setup(16'(c));
            flip(HI, c / 2);
            flip(LO, c % 2);
        end
        $display("edge test done");
        for (c = 0; c < 8; c++) begin
            setup(16'h0008 | 16'(c << 4));
            plus_mv <= HI;
            cyc(6);
            chk("result", 32'(res_n), 32'h0);
            ticks(1'b0, 1'b1);
            plus_mv <= LO;
            cyc(6);
            ticks(1'b0, 1'b0);
            chk("ticks", 32'(n), (c == 7) ? 32'h1 : 32'h1 << c);
        end
        setup(16'h0006);
        flip(HI, 1);
        osc_en <= 1'b1;
        setup(16'h0006);
        plus_mv <= LO;
        cyc(8);
        chk("result", 32'(res_n), 32'h1);
        ticks(1'b1, 1'b0);
        chk("ticks", 32'(n), 32'h1);
        setup(16'h000E);
        flip(HI, 1);
        $display("sampling test done");
        setup(16'h0003);
        low_pwr <= 1'b1;
        cyc(2);
        flip(LO, 0);
        cyc(700);
        flip(HI, 1);
        low_pwr <= 1'b0;
        cyc(2);
        flip(LO, 0);
        cyc(20);
        flip(HI, 1);
        cpu_hi <= 1'b1;
        low_pwr <= 1'b1;
        cyc(700);
        low_pwr <= 1'b0;
        cyc(22);
        flip(LO, 0);
        cyc(20);
        flip(HI, 1);
        setup(16'h0008);
        low_pwr <= 1'b1;
        plus_mv <= LO;
        cyc(6);
        ticks(1'b0, 1'b0);
        chk("ticks", 32'(n), 32'h46);
        $display("low power test done");
        tally_and_finish();
    end
    initial begin
        cyc(30000);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
